// ==== mcr_pkg.sv ====
// constants for the module configuration register block
// assumes a 21-bit core address space and a byte-wide core data bus
package mcr_pkg;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 8;

  // register locations on the core bus
  localparam logic [ADDR_W-1:0] GLOBAL_CONFIG_ADDR = 21'h00ff10;
  localparam logic [ADDR_W-1:0] CONFIG_SHADOW_ADDR = 21'h00fbfe;

  // field positions shared by global_config and config_shadow
  localparam int unsigned IO_EXPANSION_ENABLE_BIT     = 0;
  localparam int unsigned MEMORY_EXPANSION_ENABLE_BIT = 1;
  localparam int unsigned WIDE_MEMORY_SELECT_BIT      = 2;
  localparam int unsigned CLOCK_OUT_MODE_LSB          = 3;
  localparam int unsigned CLOCK_OUT_MODE_MSB          = 4;
  localparam int unsigned ZONE2_ENABLE_BIT            = 5;
  localparam int unsigned HOST_WAIT_FLAG_BIT          = 6;
  localparam int unsigned GO_TO_MONITOR_FLAG_BIT      = 7;

  // reset values: bit 7 is loaded from the monitor request after release
  localparam logic [DATA_W-1:0] GLOBAL_CONFIG_RESET = 8'h40;
  localparam logic [DATA_W-1:0] CONFIG_SHADOW_RESET = 8'h00;

  // clock-out mode codes
  localparam logic [1:0] CLOCK_OUT_RSVD0 = 2'h0;
  localparam logic [1:0] CLOCK_OUT_CORE  = 2'h1;
  localparam logic [1:0] CLOCK_OUT_SLOW  = 2'h2;
  localparam logic [1:0] CLOCK_OUT_RSVD3 = 2'h3;

  // timing: core clock rate and the slow clock-out rate, in hertz
  localparam longint unsigned CORE_CLK_HZ  = 250000000;
  localparam longint unsigned SLOW_CLK_HZ  = 32768;
  // half period in core cycles, rounded down
  localparam int unsigned SLOW_HALF_CYC = 32'(CORE_CLK_HZ / (2 * SLOW_CLK_HZ));
  localparam int unsigned DIV_W         = 12;

  // environment codes
  typedef enum logic [1:0] {
    MCR_ENV_IN_SYSTEM,
    MCR_ENV_ON_BOARD,
    MCR_ENV_DEVELOPMENT
  } mcr_env_e;
endpackage : mcr_pkg

// ==== mcr_top.sv ====
// module configuration register bank with its write-only shadow copy
// assumes a core bus with one-cycle read and write strobes on ref_clk_in;
// power mode inputs come from logic on the same clock, straps from pins.
//
// What this block does
// - reset loads 0x40 or 0xc0; bit 7 follows the monitor request.
// - config writes take effect only in active power mode, ignored otherwise; shadow writes always take effect.
// - config contents are held unchanged during idle mode.
// - shadow is write-only, decoded at 00 fbfe in the i/o zone.
// - development environment keeps pins for development use regardless of fields, except the clock-out mode field.
// - other environments let fields pick gpio or alternate function per pin.
// - bit 0 set enables the i/o zone select for expansion logic.
// - bit 1 set gives zone 0 select and lines to external memory.
// - bit 2 picks 8-bit or 16-bit external memory when enabled.
// - bits 4-3 act only with clock-out as output; 01 gives core clock.
// - code 10 drives a 32.768 khz clock; code 11 is reserved.
// - bit 6 set by reset, cleared by writing one; host cycles wait meanwhile.
// - bit 5 gives zone 2 the memory range, else zone 0 takes it.
`timescale 1ns/1ps
module mcr_top (
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_n_in,
  input  wire logic [mcr_pkg::ADDR_W-1:0] core_addr_in,
  input  wire logic                      core_wr_in,
  input  wire logic                      core_rd_in,
  input  wire logic [mcr_pkg::DATA_W-1:0] core_wdata_in,
  input  wire logic                      active_mode_in,
  input  wire logic                      idle_mode_in,
  input  wire logic                      clock_out_is_output_in,
  input  wire logic                      go_to_monitor_req_in,
  input  wire logic                      in_system_environment_in,
  input  wire logic                      development_environment_in,
  output logic      [mcr_pkg::DATA_W-1:0] core_rdata_out,
  output logic      [mcr_pkg::DATA_W-1:0] config_shadow_out,
  output logic                           dev_pins_hold_out,
  output logic                           io_zone_select_en_out,
  output logic                           zone0_select_en_out,
  output logic                           wide_memory_out,
  output logic                           zone2_select_en_out,
  output logic                           zone0_low_range_out,
  output logic                           host_wait_flag_out,
  output logic                           clock_out_core_sel_out,
  output logic                           clock_out_pin_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic       rst_meta;
  logic       rst_n;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // async assert, synchronous release
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // straps are not reset so their level is valid at the moment of release
  always_ff @(posedge ref_clk_in) begin
    pin_meta <= {go_to_monitor_req_in, in_system_environment_in,
                 development_environment_in};
    pin_sync <= pin_meta;
  end

  logic mon_req_q;
  logic dev_env_q;
  assign mon_req_q = pin_sync[2];
  assign dev_env_q = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic hit(input logic [mcr_pkg::ADDR_W-1:0] a,
                               input logic [mcr_pkg::ADDR_W-1:0] loc);
    hit = (a == loc);
  endfunction : hit

  logic wr_cfg;
  logic wr_shd;
  logic rd_cfg;
  assign wr_cfg = core_wr_in && hit(core_addr_in, mcr_pkg::GLOBAL_CONFIG_ADDR);
  assign wr_shd = core_wr_in && hit(core_addr_in, mcr_pkg::CONFIG_SHADOW_ADDR);
  assign rd_cfg = core_rd_in && hit(core_addr_in, mcr_pkg::GLOBAL_CONFIG_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // configuration register and shadow

  logic [mcr_pkg::DATA_W-1:0] global_config;
  logic [mcr_pkg::DATA_W-1:0] next_global_config;
  logic [mcr_pkg::DATA_W-1:0] config_shadow;
  logic [mcr_pkg::DATA_W-1:0] next_config_shadow;
  logic                       strap_taken;
  logic                       next_strap_taken;
  logic [mcr_pkg::DATA_W-1:0] core_rdata;
  logic [mcr_pkg::DATA_W-1:0] next_core_rdata;

  // config writes honoured only in active, non-idle mode; shadow writes always honoured
  always_comb begin
    next_global_config = global_config;
    next_config_shadow = config_shadow;
    next_strap_taken   = 1'b1;
    if (!strap_taken) begin
      next_global_config[mcr_pkg::GO_TO_MONITOR_FLAG_BIT] = mon_req_q;
    end else if (wr_cfg && active_mode_in && !idle_mode_in) begin
      next_global_config[5:0] = core_wdata_in[5:0];
      // host wait: write one clears, write zero leaves it alone
      if (core_wdata_in[mcr_pkg::HOST_WAIT_FLAG_BIT]) begin
        next_global_config[mcr_pkg::HOST_WAIT_FLAG_BIT] = 1'b0;
      end
      // monitor flag can only be cleared by software, never set
      if (!core_wdata_in[mcr_pkg::GO_TO_MONITOR_FLAG_BIT]) begin
        next_global_config[mcr_pkg::GO_TO_MONITOR_FLAG_BIT] = 1'b0;
      end
    end
    if (wr_shd) begin
      next_config_shadow = core_wdata_in;
    end
    // shadow never reads back; unmapped addresses read zero too
    next_core_rdata = rd_cfg ? global_config : '0;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      global_config <= mcr_pkg::GLOBAL_CONFIG_RESET;
      config_shadow <= mcr_pkg::CONFIG_SHADOW_RESET;
      strap_taken   <= 1'b0;
      core_rdata    <= '0;
    end else begin
      global_config <= next_global_config;
      config_shadow <= next_config_shadow;
      strap_taken   <= next_strap_taken;
      core_rdata    <= next_core_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin assignment from fields

  logic       io_en;
  logic       mem_en;
  logic [1:0] clk_mode;
  assign io_en    = global_config[mcr_pkg::IO_EXPANSION_ENABLE_BIT];
  assign mem_en   = global_config[mcr_pkg::MEMORY_EXPANSION_ENABLE_BIT];
  assign clk_mode = global_config[mcr_pkg::CLOCK_OUT_MODE_MSB:mcr_pkg::CLOCK_OUT_MODE_LSB];

  logic next_dev_hold;
  logic next_io_zone;
  logic next_zone0;
  logic next_wide;
  logic next_zone2;
  logic next_low_range;
  logic next_core_sel;
  logic dev_hold;
  logic io_zone;
  logic zone0;
  logic wide;
  logic zone2;
  logic low_range;
  logic core_sel;

  // development environment owns the zone pins; clock-out mode steers in every environment
  always_comb begin
    next_dev_hold  = dev_env_q;
    next_io_zone   = !dev_env_q && io_en;
    next_zone0     = !dev_env_q && mem_en;
    next_wide      = !dev_env_q && mem_en
                     && global_config[mcr_pkg::WIDE_MEMORY_SELECT_BIT];
    next_zone2     = !dev_env_q && mem_en
                     && global_config[mcr_pkg::ZONE2_ENABLE_BIT];
    next_low_range = !dev_env_q && mem_en
                     && !global_config[mcr_pkg::ZONE2_ENABLE_BIT];
    next_core_sel  = clock_out_is_output_in
                     && (clk_mode == mcr_pkg::CLOCK_OUT_CORE);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dev_hold  <= 1'b0;
      io_zone   <= 1'b0;
      zone0     <= 1'b0;
      wide      <= 1'b0;
      zone2     <= 1'b0;
      low_range <= 1'b0;
      core_sel  <= 1'b0;
    end else begin
      dev_hold  <= next_dev_hold;
      io_zone   <= next_io_zone;
      zone0     <= next_zone0;
      wide      <= next_wide;
      zone2     <= next_zone2;
      low_range <= next_low_range;
      core_sel  <= next_core_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slow clock-out divider
  // the core-rate clock itself cannot come from a flop; the pad mux takes
  // the core clock when clock_out_core_sel_out is high

  logic [mcr_pkg::DIV_W-1:0] div_cnt;
  logic [mcr_pkg::DIV_W-1:0] next_div_cnt;
  logic                      slow_clk;
  logic                      next_slow_clk;
  logic                      slow_on;
  assign slow_on = clock_out_is_output_in && (clk_mode == mcr_pkg::CLOCK_OUT_SLOW);

  // reserved codes and input direction park the pin low
  always_comb begin
    next_div_cnt  = '0;
    next_slow_clk = 1'b0;
    if (slow_on) begin
      next_slow_clk = slow_clk;
      if (div_cnt == mcr_pkg::DIV_W'(mcr_pkg::SLOW_HALF_CYC - 1)) begin
        next_slow_clk = !slow_clk;
      end else begin
        next_div_cnt = div_cnt + mcr_pkg::DIV_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= '0;
      slow_clk <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      slow_clk <= next_slow_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign core_rdata_out         = core_rdata;
  assign config_shadow_out      = config_shadow;
  assign dev_pins_hold_out      = dev_hold;
  assign io_zone_select_en_out  = io_zone;
  assign zone0_select_en_out    = zone0;
  assign wide_memory_out        = wide;
  assign zone2_select_en_out    = zone2;
  assign zone0_low_range_out    = low_range;
  assign host_wait_flag_out     = global_config[mcr_pkg::HOST_WAIT_FLAG_BIT];
  assign clock_out_core_sel_out = core_sel;
  assign clock_out_pin_out      = slow_clk;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence seq_cfg_write_blocked;
    wr_cfg && strap_taken && !(active_mode_in && !idle_mode_in);
  endsequence

  sequence seq_cfg_write_ok;
    wr_cfg && strap_taken && active_mode_in && !idle_mode_in;
  endsequence

  sequence seq_shadow_write;
    wr_shd;
  endsequence

  AST_RESET_VALUE: assert property (
    !strap_taken |-> global_config[6:0] == 7'h40 ##1 global_config[7] == $past(mon_req_q))
    else $error("config reset value wrong");

  AST_WRITE_IGNORED: assert property (
    seq_cfg_write_blocked |=> global_config == $past(global_config))
    else $error("config changed outside active mode");

  AST_IDLE_HOLD: assert property (
    idle_mode_in && strap_taken |=> $stable(global_config))
    else $error("config changed during idle");

  AST_LOW_FIELDS_WRITTEN: assert property (
    seq_cfg_write_ok |=> global_config[5:0] == $past(core_wdata_in[5:0]))
    else $error("active write not stored");

  AST_SHADOW_WO: assert property (
    core_rd_in && hit(core_addr_in, mcr_pkg::CONFIG_SHADOW_ADDR) |=> core_rdata_out == 8'h00)
    else $error("shadow read returned data");

  AST_SHADOW_MIRROR: assert property (
    seq_shadow_write |=> config_shadow_out == $past(core_wdata_in))
    else $error("shadow not loaded");

  AST_DEV_HOLDS_PINS: assert property (
    dev_env_q |=> dev_pins_hold_out && !io_zone_select_en_out && !zone0_select_en_out)
    else $error("fields steered pins in development environment");

  AST_IO_ZONE: assert property (
    !dev_env_q && io_en |=> io_zone_select_en_out)
    else $error("i/o zone select not enabled");

  AST_MEM_ZONES: assert property (
    !dev_env_q && mem_en |=> zone0_select_en_out && (zone2_select_en_out != zone0_low_range_out))
    else $error("memory zone select wrong");

  AST_HOST_WAIT_STICKY: assert property (
    seq_cfg_write_ok ##0 !core_wdata_in[6] ##0 global_config[6] |=> host_wait_flag_out)
    else $error("host wait cleared by zero write");

  // the enable that governed the toggle is the one of the previous edge;
  // a mode change in that same edge must not be blamed on the divider
  AST_SLOW_CLK_HALF: assert property (
    $past(slow_on) && $changed(slow_clk)
      |-> $past(div_cnt) == mcr_pkg::DIV_W'(mcr_pkg::SLOW_HALF_CYC - 1))
    else $error("slow clock half period wrong");

endmodule : mcr_top

// ==== testbench.sv ====
// self-checking bench for the module configuration register bank
// assumes mcr_pkg and mcr_top are compiled first; inputs change at falling edges
`timescale 1ns/1ps
module testbench;
  logic                         clk         = 1'b0;
  logic                         rst_n       = 1'b0;
  logic [mcr_pkg::ADDR_W-1:0]   addr        = '0;
  logic                         wr_s        = 1'b0;
  logic                         rd_s        = 1'b0;
  logic [mcr_pkg::DATA_W-1:0]   wdata       = '0;
  logic                         active      = 1'b1;
  logic                         idle_m      = 1'b0;
  logic                         clk_out_dir = 1'b0;
  logic                         mon_req     = 1'b0;
  logic                         in_sys      = 1'b1;
  logic                         dev_env     = 1'b0;
  logic [mcr_pkg::DATA_W-1:0]   rdata;
  logic [mcr_pkg::DATA_W-1:0]   shadow;
  logic                         dev_hold, io_en, z0_en, wide, z2_en, low_rng;
  logic                         host_wait, core_sel, pin;
  int                           fails       = 0;
  int                           checks      = 0;
  localparam logic [20:0]       GA          = mcr_pkg::GLOBAL_CONFIG_ADDR;
  localparam logic [20:0]       SA          = mcr_pkg::CONFIG_SHADOW_ADDR;

  ////////////////////////////////////////////////////////////////////////////////
  // 250 MHz core clock
  always #2 clk = ~clk;

  mcr_top u_dut (
    .ref_clk_in                 (clk),
    .reset_n_in                 (rst_n),
    .core_addr_in               (addr),
    .core_wr_in                 (wr_s),
    .core_rd_in                 (rd_s),
    .core_wdata_in              (wdata),
    .active_mode_in             (active),
    .idle_mode_in               (idle_m),
    .clock_out_is_output_in     (clk_out_dir),
    .go_to_monitor_req_in       (mon_req),
    .in_system_environment_in   (in_sys),
    .development_environment_in (dev_env),
    .core_rdata_out             (rdata),
    .config_shadow_out          (shadow),
    .dev_pins_hold_out          (dev_hold),
    .io_zone_select_en_out      (io_en),
    .zone0_select_en_out        (z0_en),
    .wide_memory_out            (wide),
    .zone2_select_en_out        (z2_en),
    .zone0_low_range_out        (low_rng),
    .host_wait_flag_out         (host_wait),
    .clock_out_core_sel_out     (core_sel),
    .clock_out_pin_out          (pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // comparison and closing
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  // core bus cycles: one strobe cycle each, launched at a falling edge
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic wr(input logic [20:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr_s  = 1'b1;
    @(negedge clk);
    wr_s  = 1'b0;
    idle(3); // field outputs lag the register by one more cycle
  endtask : wr

  task automatic rdchk(input string name, input logic [20:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk(name, rdata, exp); // read data stands only in the cycle after the strobe
  endtask : rdchk

  // pin routing outputs packed as dev, io, zone0, wide, zone2, low range
  task automatic fields(input logic [7:0] exp);
    chk("fields", {2'h0, dev_hold, io_en, z0_en, wide, z2_en, low_rng}, exp);
  endtask : fields

  // called at time zero or at a falling edge, so reset spans five rising edges
  task automatic do_reset(input logic mon);
    rst_n   = 1'b0;
    mon_req = mon; // strap settles well before release
    idle(5);
    rst_n   = 1'b1;
    idle(6);
  endtask : do_reset

  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask : done

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    do_reset(1'b0);
    rdchk("config", GA, 8'h40);
    chk("host_wait", {7'h0, host_wait}, 8'h01);
    fields(8'h00);
    chk("shadow", shadow, 8'h00);
    wr(SA, 8'h40);
    chk("shadow", shadow, 8'h40);
    rdchk("shadow_read", SA, 8'h00);
    done("reset");

    wr(GA, 8'h00);
    rdchk("config", GA, 8'h40);
    wr(GA, 8'h43);
    wr(SA, 8'h03);
    rdchk("config", GA, 8'h03);
    chk("host_wait", {7'h0, host_wait}, 8'h00);
    fields(8'h19);
    chk("shadow", shadow, 8'h03);
    done("write");

    active = 1'b0;
    wr(GA, 8'h26);
    rdchk("config", GA, 8'h03);
    active = 1'b1;
    idle_m = 1'b1;
    wr(GA, 8'h26);
    rdchk("config", GA, 8'h03);
    fields(8'h19);
    idle_m = 1'b0;
    done("power_modes");

    wr(GA, 8'h26);
    fields(8'h0e);
    wr(GA, 8'h24);
    fields(8'h00);
    wr(GA, 8'h22);
    fields(8'h0a);
    done("memory");

    wr(GA, 8'h27);
    dev_env = 1'b1;
    idle(6);
    fields(8'h20);
    dev_env = 1'b0;
    idle(6);
    fields(8'h1e);
    wr(21'h00ff11, 8'h00);
    rdchk("unmapped", 21'h00ff11, 8'h00);
    rdchk("config", GA, 8'h27);
    done("environment");

    // every clock-out code with the pin as output
    clk_out_dir = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(GA, {3'h0, m[1:0], 3'h0});
      chk("core_sel", {7'h0, core_sel}, (m == 1) ? 8'h01 : 8'h00);
      chk("pin", {7'h0, pin}, 8'h00);
    end
    clk_out_dir = 1'b0;
    wr(GA, 8'h08);
    chk("core_sel", {7'h0, core_sel}, 8'h00);
    clk_out_dir = 1'b1;
    wr(GA, 8'h10);
    idle(3700);
    chk("pin", {7'h0, pin}, 8'h00);
    idle(200);
    chk("pin", {7'h0, pin}, 8'h01);
    done("clock_out");

    do_reset(1'b1);
    rdchk("config", GA, 8'hc0);
    wr(GA, 8'h80);
    rdchk("config", GA, 8'hc0);
    wr(GA, 8'h00);
    rdchk("config", GA, 8'h40);
    done("monitor");
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need about 4000 cycles, this allows over twelve times that
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule : testbench
